/* File: ddsl_load_ctrl.sv */
// serial load control of a dual converter: link-side shift register,
// word crossing on chip select release, fifo, input and output registers.
// assumes serial_clk runs only while chip select is low, and that the host
// keeps chip select high for at least four core_clk periods between frames.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Behaviour
// - serial data pin goes straight into the shift register, no buffer stage
// - one data bit is captured on every rising serial clock edge while chip select is low
// - with chip select high, clock edges are ignored, shift register holds
// - chip select rising copies the payload into the addressed input register only
// - output register loading depends on the load strobe alone, never chip select
// - load strobe low makes both output registers follow inputs; latch on release
// - preset low forces the input and output registers to zero or midscale per select pin
// - select pin picks the same preset for reset pulse and power-on
// - word is 16 bits msb first; only the last 16 bits count
// - two address bits pick which channel takes the 14-bit code
module ddsl_load_ctrl
  import ddsl_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              serial_clk,
  input  wire logic              serial_data_in,
  input  wire logic              chip_select_n,
  input  wire logic              load_outputs_n,
  input  wire logic              preset_n,
  input  wire logic              midscale_sel,
  output logic      [CODE_W-1:0] input_code_a,
  output logic      [CODE_W-1:0] input_code_b,
  output logic      [CODE_W-1:0] sample_code_a,
  output logic      [CODE_W-1:0] sample_code_b,
  output logic                   word_ready,
  output logic                   word_dropped,
  output logic                   preset_active
);

  typedef enum logic [1:0] {
    DDSL_IDLE,
    DDSL_SELECT,
    DDSL_PUSH
  } ddsl_frame_e;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // channel enable {b, a} from the two address bits; ADDR_BOTH sets both
  function automatic logic [1:0] ddsl_chan_en(input logic [ADDR_W-1:0] addr);
    logic [1:0] en;
    en = 2'h0;
    case (addr)
      ADDR_A:    en = 2'h1;
      ADDR_B:    en = 2'h2;
      ADDR_BOTH: en = 2'h3;
      ADDR_NONE: en = 2'h0;
      default:   en = 2'h0;
    endcase
    return en;
  endfunction

  function automatic logic [CODE_W-1:0] ddsl_preset(input logic mid);
    return mid ? PRESET_MID : PRESET_ZERO;
  endfunction

  initial begin
    if (DEPTH < 2) $error("ddsl_load_ctrl: DEPTH must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: shift register on serial_clk

  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;

  // chip select is sampled at the same edge as the data; a synchroniser here
  // would cost two edges of a frame whose clock stops when it ends
  always_comb begin
    shift_d = {shift_q[WORD_W-2:0], serial_data_in};
  end

  always_ff @(posedge serial_clk) begin
    if (!chip_select_n) begin
      shift_q <= shift_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core domain: synchronised pins

  logic [3:0] pins_async;
  logic [3:0] pins_sync;
  logic       cs_n_s;
  logic       load_n_s;
  logic       preset_n_s;
  logic       mid_s;

  assign pins_async = {midscale_sel, preset_n, load_outputs_n, chip_select_n};

  ddsl_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk      (core_clk),
    .rst      (rst),
    .async_in (pins_async),
    .reset_val(4'hf),
    .sync_out (pins_sync)
  );

  assign cs_n_s     = pins_sync[0];
  assign load_n_s   = pins_sync[1];
  assign preset_n_s = pins_sync[2];
  assign mid_s      = pins_sync[3];

  ////////////////////////////////////////////////////////////////////////////////
  // power-on preset hold

  logic [2:0] init_cnt_q;
  logic       init_active;

  assign init_active = (init_cnt_q != 3'h0);

  // the strap is only trusted once it has passed the synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      init_cnt_q <= 3'(INIT_HOLD);
    end else if (init_active) begin
      init_cnt_q <= init_cnt_q - 3'h1;
    end
  end

  logic preset_now;

  assign preset_now    = init_active || !preset_n_s;
  assign preset_active = preset_now;

  ////////////////////////////////////////////////////////////////////////////////
  // frame tracking and word crossing

  ddsl_frame_e       frame_q;
  logic [WORD_W-1:0] word_q;
  logic              push_valid;
  logic              fifo_in_ready;

  // the shift register is still while chip select is high, so it is read
  // as a quasi-static word once the synchronised release is seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_q <= DDSL_IDLE;
    end else begin
      case (frame_q)
        DDSL_IDLE: begin
          if (!cs_n_s) frame_q <= DDSL_SELECT;
        end
        DDSL_SELECT: begin
          if (cs_n_s) frame_q <= DDSL_PUSH;
        end
        DDSL_PUSH: begin
          frame_q <= cs_n_s ? DDSL_IDLE : DDSL_SELECT;
        end
        default: begin
          frame_q <= DDSL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_q <= '0;
    end else if (frame_q == DDSL_SELECT && cs_n_s) begin
      word_q <= shift_q;
    end
  end

  assign push_valid = (frame_q == DDSL_PUSH);
  assign word_ready = fifo_in_ready;

  // a word that finds the fifo full is lost; the host sees word_ready low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_dropped <= 1'b0;
    end else if (push_valid && !fifo_in_ready) begin
      word_dropped <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word fifo

  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  // draining stalls while a preset is forced so no word slips past it
  assign fifo_out_ready = !preset_now;

  ddsl_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_word_fifo (
    .clk      (core_clk),
    .rst      (rst),
    .in_valid (push_valid),
    .in_ready (fifo_in_ready),
    .in_data  (word_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // input registers

  logic [ADDR_W-1:0] word_addr;
  logic [CODE_W-1:0] word_code;
  logic [1:0]        chan_en;
  logic              pop;

  assign word_addr = fifo_out_data[ADDR_HI_POS:ADDR_LO_POS];
  assign word_code = fifo_out_data[CODE_MSB:CODE_LSB];
  assign chan_en   = ddsl_chan_en(word_addr);
  assign pop       = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge core_clk) begin
    if (rst || preset_now) begin
      input_code_a <= ddsl_preset(mid_s);
    end else if (pop && chan_en[0]) begin
      input_code_a <= word_code;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || preset_now) begin
      input_code_b <= ddsl_preset(mid_s);
    end else if (pop && chan_en[1]) begin
      input_code_b <= word_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output registers, loaded by the strobe alone

  always_ff @(posedge core_clk) begin
    if (rst || preset_now) begin
      sample_code_a <= ddsl_preset(mid_s);
      sample_code_b <= ddsl_preset(mid_s);
    end else if (!load_n_s) begin
      sample_code_a <= input_code_a;
      sample_code_b <= input_code_b;
    end
  end

endmodule // ddsl_load_ctrl

/* File: ddsl_pkg.sv */
// constants shared by the serial load control block and its helpers
// assumes a 16-bit command word with two address bits above a 14-bit code
package ddsl_pkg;

  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CODE_W      = 14;
  localparam int unsigned ADDR_W      = 2;
  localparam int unsigned ADDR_HI_POS = 15;
  localparam int unsigned ADDR_LO_POS = 14;
  localparam int unsigned CODE_MSB    = 13;
  localparam int unsigned CODE_LSB    = 0;

  localparam logic [CODE_W-1:0] PRESET_ZERO = 14'h0000;
  localparam logic [CODE_W-1:0] PRESET_MID  = 14'h2000;

  // channel address decode; codes without a channel load nothing
  localparam logic [ADDR_W-1:0] ADDR_NONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_A    = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_B    = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_BOTH = 2'h3;

  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned SYNC_STAGES = 2;
  // power-on preset is held long enough for the select pin to pass its synchroniser
  localparam int unsigned INIT_HOLD   = SYNC_STAGES + 2;

  localparam int unsigned CORE_CLK_PERIOD_NS = 25;

endpackage

/* File: ddsl_sync.sv */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no word coherence across bits
`timescale 1ns/1ps

module ddsl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("ddsl_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q   <= async_in;
    if (rst) begin
      sync_out <= reset_val;
    end else begin
      sync_out <= meta_q;
    end
  end

endmodule // ddsl_sync

/* File: ddsl_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; read data is shown ahead from the storage array
`timescale 1ns/1ps

module ddsl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ddsl_fifo: DEPTH must be 2^n, n>0");
    if (WIDTH < 1) $error("ddsl_fifo: WIDTH must be at least 1");
  end

  assign in_ready  = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      case ({push, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule // ddsl_fifo

/* File: ddsl_load_ctrl_properties.sv */
// port checker for the dual converter serial load control
// assumes it is bound onto every ddsl_load_ctrl instance
`timescale 1ns/1ps

module ddsl_load_ctrl_chk
  import ddsl_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              chip_select_n,
  input wire logic              load_outputs_n,
  input wire logic              midscale_sel,
  input wire logic [CODE_W-1:0] input_code_a,
  input wire logic [CODE_W-1:0] input_code_b,
  input wire logic [CODE_W-1:0] sample_code_a,
  input wire logic [CODE_W-1:0] sample_code_b,
  input wire logic              word_ready,
  input wire logic              word_dropped,
  input wire logic              preset_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  a_preset_all_equal: assert property (
    preset_active [*2] |-> input_code_a == input_code_b &&
      sample_code_a == input_code_a && sample_code_b == input_code_a)
    else $error("preset left registers unequal");
  // select must be settled past its synchroniser before the value is judged
  a_preset_sel_value: assert property (
    preset_active [*2] ##0 $past(midscale_sel, 4) == midscale_sel |->
      input_code_a == (midscale_sel ? PRESET_MID : PRESET_ZERO))
    else $error("preset value does not match select");
  a_init_hold: assert property (
    $fell(rst) |-> preset_active [*3])
    else $error("power-on preset hold too short");
  a_strobe_follow: assert property (
    (!load_outputs_n && !preset_active) [*4] |->
      sample_code_a == $past(input_code_a) && sample_code_b == $past(input_code_b))
    else $error("output registers not transparent");
  a_strobe_latch: assert property (
    (load_outputs_n && !preset_active) [*5] |->
      $stable(sample_code_a) && $stable(sample_code_b))
    else $error("output registers moved without strobe");
  a_frame_quiet: assert property (
    (!chip_select_n && !preset_active) [*8] |->
      $stable(input_code_a) && $stable(input_code_b))
    else $error("input register changed inside a frame");
  a_drop_sticky: assert property (word_dropped |=> word_dropped)
    else $error("dropped flag cleared");
  a_drop_cause: assert property ($rose(word_dropped) |-> !$past(word_ready))
    else $error("word dropped while fifo had room");
endmodule // ddsl_load_ctrl_chk

bind ddsl_load_ctrl ddsl_load_ctrl_chk u_chk (.core_clk, .rst, .chip_select_n,
  .load_outputs_n, .midscale_sel, .input_code_a, .input_code_b, .sample_code_a,
  .sample_code_b, .word_ready, .word_dropped, .preset_active);

/* File: ddsl_host_model.sv */
// serial master model for the three-wire load link, 6 ns link clock
// assumes the bench calls send; the clock idles low between frames
`timescale 1ns/1ps

module ddsl_host_model (
  output logic serial_clk,
  output logic serial_data_in,
  output logic chip_select_n
);
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    chip_select_n = 1'b1;
  end

  // framed=0 clocks with select high on purpose, to prove edges are ignored
  task automatic send(input logic [63:0] bits, input int n, input logic framed);
    chip_select_n = !framed;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = bits[i];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    #3 chip_select_n = 1'b1;
    serial_data_in = !serial_data_in;
  endtask
endmodule // ddsl_host_model

/* File: ddsl_load_ctrl_tb_top.sv */
// self-checking bench for the serial load control
// assumes host model and bound checker compiled alongside
`timescale 1ns/1ps

module ddsl_load_ctrl_tb_top
  import ddsl_pkg::*;
;
  logic core_clk, rst, load_outputs_n, preset_n, midscale_sel;
  logic serial_clk, serial_data_in, chip_select_n;
  logic word_ready, word_dropped, preset_active;
  logic [CODE_W-1:0] input_code_a, input_code_b, sample_code_a, sample_code_b, ea, eb;
  int mismatches, cmp_count;

  ddsl_host_model u_ddsl_host_model (.serial_clk, .serial_data_in, .chip_select_n);
  ddsl_load_ctrl u_ddsl_load_ctrl (.core_clk, .rst, .serial_clk, .serial_data_in,
    .chip_select_n, .load_outputs_n, .preset_n, .midscale_sel, .input_code_a,
    .input_code_b, .sample_code_a, .sample_code_b, .word_ready, .word_dropped,
    .preset_active);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk14(input logic [CODE_W-1:0] act, input logic [CODE_W-1:0] exp);
    cmp_count++;
    if (act !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic chk1(input logic act, input logic exp);
    cmp_count++;
    if (act !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // eight core cycles covers the gap between frames and the crossing latency
  task automatic xfer(input logic [63:0] bits, input int n);
    u_ddsl_host_model.send(bits, n, 1'b1);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic wait_free();
    int k;
    k = 0;
    while (preset_active !== 1'b0 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    if (preset_active !== 1'b0) begin
      mismatches++;
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    load_outputs_n = 1'b1;
    preset_n = 1'b1;
    midscale_sel = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    chk1(preset_active, 1'b1);
    wait_free();
    chk14(sample_code_a, PRESET_MID);
    chk14(input_code_b, PRESET_MID);
    xfer(64'h40a5, 16);
    chk14(input_code_a, 14'h00a5);
    chk14(input_code_b, PRESET_MID);
    chk14(sample_code_a, PRESET_MID);
    u_ddsl_host_model.send(64'hff, 8, 1'b0);
    xfer(64'h3c, 8);
    chk14(input_code_b, 14'h253c);
    ea = 14'h00a5;
    eb = 14'h253c;
    for (int a = 0; a < 4; a++) begin
      xfer({a[1:0], 14'h1230 + 14'(a)}, 16);
      if (a[0]) ea = 14'h1230 + 14'(a);
      if (a[1]) eb = 14'h1230 + 14'(a);
      chk14(input_code_a, ea);
      chk14(input_code_b, eb);
    end
    xfer(64'habcdef9abc, 40);
    chk14(input_code_b, 14'h1abc);
    chk14(input_code_a, ea);
    load_outputs_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk14(sample_code_a, ea);
    chk14(sample_code_b, 14'h1abc);
    xfer(64'h5555, 16);
    chk14(sample_code_a, 14'h1555);
    load_outputs_n = 1'b1;
    repeat (4) @(negedge core_clk);
    xfer(64'h8001, 16);
    chk14(input_code_b, 14'h0001);
    chk14(sample_code_b, 14'h1abc);
    midscale_sel = 1'b0;
    repeat (6) @(negedge core_clk);
    preset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    chk14(input_code_a, PRESET_ZERO);
    chk14(sample_code_b, PRESET_ZERO);
    // words queue while the preset stalls the drain; the ninth overflows
    for (int i = 0; i < 9; i++) xfer({2'h1, 14'(i)}, 16);
    chk1(word_ready, 1'b0);
    chk1(word_dropped, 1'b1);
    preset_n = 1'b1;
    wait_free();
    repeat (12) @(negedge core_clk);
    chk14(input_code_a, 14'h0007);
    chk14(input_code_b, PRESET_ZERO);
    chk14(sample_code_a, PRESET_ZERO);
    summarize();
  end
endmodule // ddsl_load_ctrl_tb_top
